// >>> core/gic_consts.svh
`ifndef GIC_CONSTS_SVH
`define GIC_CONSTS_SVH
// Register byte offsets (A7:A0)
`define GIC_OFF_REQ 8'h80
`define GIC_OFF_CODE_LO 8'h81
`define GIC_OFF_CODE_MID 8'h82
`define GIC_OFF_CODE_HI 8'h83
`define GIC_OFF_TMR_CMD 8'h84
`define GIC_OFF_TMR_RSVD 8'h85
`define GIC_OFF_TMR_LO 8'h86
`define GIC_OFF_TMR_HI 8'h87
`define GIC_OFF_SAMPLE 8'h88
`define GIC_OFF_ANC_A 8'h89
`define GIC_OFF_SOFT_RST 8'h8a
`define GIC_OFF_SLEEP 8'h8b
`define GIC_OFF_REV 8'h8c
`define GIC_OFF_IDENT 8'h8d
`define GIC_OFF_ANC_B 8'h8e
`define GIC_OFF_PIN_MASK 8'h8f
`define GIC_OFF_PIN_LVL 8'h90
`define GIC_OFF_PIN_TRI 8'h91
`define GIC_OFF_PIN_INV 8'h92
`define GIC_OFF_PIN_SEL 8'h93
// Reset values
`define GIC_RST_BYTE 8'h00
`define GIC_RST_PIN_SEL 8'hff
// Code field positions in the interrupt word
`define GIC_CODE0_LSB 8
`define GIC_CODE1_LSB 11
`define GIC_CODE_W 3
// Timer control readback when an enabled timer event is pending
`define GIC_TMR_PEND_RD 8'h01
`endif

// >>> core/gic_pkg.sv
package gic_pkg;
    // Source codes, highest priority first after none
    typedef enum logic [2:0] {
        GIC_SRC_NONE = 3'h0,
        GIC_SRC_RX = 3'h1,
        GIC_SRC_RXTO = 3'h2,
        GIC_SRC_TX = 3'h3,
        GIC_SRC_MODEM = 3'h4,
        GIC_SRC_RSVD = 3'h5,
        GIC_SRC_PIN = 3'h6,
        GIC_SRC_TIMER = 3'h7
    } gic_src_t;
endpackage

// >>> core/gic_global_int.sv
`timescale 1ns/10ps
`include "gic_consts.svh"
module gic_global_int #(
    parameter int NCH = 2,
    parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] IDENT_CODE = 8'h5a // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Byte-lane register port
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [3:0] byteEn,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    // Per-channel source levels and event pulses, same clock domain
    input wire logic [NCH-1:0] rxReadyLvl,
    input wire logic [NCH-1:0] rxTimeoutLvl,
    input wire logic [NCH-1:0] lineErrEvt,
    input wire logic [NCH-1:0] txReadyEvt,
    input wire logic [NCH-1:0] flowCharEvt,
    input wire logic [NCH-1:0] modemEvt,
    input wire logic [NCH-1:0] handshakeEvt,
    input wire logic [NCH-1:0] specialCharEvt,
    input wire logic [NCH-1:0] charRxEvt,
    // Channel register reads that clear sources
    input wire logic [NCH-1:0] lineStatusRd,
    input wire logic [NCH-1:0] intStatusRd,
    input wire logic [NCH-1:0] modemStatusRd,
    // Device-wide sources
    input wire logic timerEvt,
    input wire logic timerIntEn,
    input wire logic pinEvt,
    input wire logic wakeEvt,
    input wire logic softResetDone,
    // Configuration outputs
    output logic [7:0] timerCmd,
    output logic timerCmdStb,
    output logic [15:0] timerPeriod,
    output logic [7:0] samplingRate,
    output logic [7:0] softReset,
    output logic [7:0] sleepCtrl,
    output logic [7:0] pinMask,
    output logic [7:0] pinLevel,
    output logic [7:0] pinTristate,
    output logic [7:0] pinPolarity,
    output logic [7:0] pinSelect,
    output logic [NCH-1:0] chanRequest
);

    // Elaboration guard: the interrupt word has code fields for two channels only
    if (NCH != 2) begin : g_nch_check
        $error("gic_global_int serves exactly two channels");
    end

    // ==========================================================
    // Byte lane decode
    // ==========================================================
    logic [3:0] laneRd;
    logic [3:0] laneWr;
    logic [7:0] laneAddr [4];

    // Lane i addresses start address plus i; width set by enables
    genvar li;
    generate
        for (li = 0; li < 4; li++) begin : g_lane
            assign laneAddr[li] = regAddr + 8'(li);
            assign laneRd[li] = clkEn & regRd & byteEn[li];
            assign laneWr[li] = clkEn & regWr & byteEn[li];
        end
    endgenerate

    // True when any enabled lane of the access lands on the offset
    function automatic logic hit(input logic [3:0] acc, input logic [7:0] off);
        logic h;
        h = 1'b0;
        for (int k = 0; k < 4; k++) begin
            h = h | (acc[k] & (laneAddr[k] == off));
        end
        return h;
    endfunction

    // Byte that the access carries for one offset, zero if no lane covers it
    function automatic logic [7:0] wbyte(input logic [7:0] off);
        logic [7:0] v;
        v = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (laneAddr[k] == off) begin
                v = regWrData[8*k +: 8];
            end
        end
        return v;
    endfunction

    // ==========================================================
    // Sticky source flags
    // ==========================================================
    logic [NCH-1:0] lineErrFlag;
    logic [NCH-1:0] txReadyFlag;
    logic [NCH-1:0] flowCharFlag;
    logic [NCH-1:0] modemFlag;
    logic [NCH-1:0] handshakeFlag;
    logic [NCH-1:0] specialFlag;
    logic timerFlag;
    logic pinFlag;
    logic wakeFlag;
    logic reqRead;
    logic timerCmdRead;
    logic pinLvlRead;

    assign reqRead = hit(laneRd, `GIC_OFF_REQ);
    assign timerCmdRead = hit(laneRd, `GIC_OFF_TMR_CMD);
    assign pinLvlRead = hit(laneRd, `GIC_OFF_PIN_LVL);

    // Set wins over clear so no event is lost in the clearing cycle
    genvar ci;
    generate
        for (ci = 0; ci < NCH; ci++) begin : g_chan
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    lineErrFlag[ci] <= 1'b0;
                    txReadyFlag[ci] <= 1'b0;
                    flowCharFlag[ci] <= 1'b0;
                    modemFlag[ci] <= 1'b0;
                    handshakeFlag[ci] <= 1'b0;
                    specialFlag[ci] <= 1'b0;
                end else if (clkEn) begin
                    lineErrFlag[ci] <= lineErrEvt[ci] |
                        (lineErrFlag[ci] & ~lineStatusRd[ci]);
                    txReadyFlag[ci] <= txReadyEvt[ci] |
                        (txReadyFlag[ci] & ~intStatusRd[ci]);
                    flowCharFlag[ci] <= flowCharEvt[ci] |
                        (flowCharFlag[ci] & ~intStatusRd[ci]);
                    modemFlag[ci] <= modemEvt[ci] |
                        (modemFlag[ci] & ~modemStatusRd[ci]);
                    handshakeFlag[ci] <= handshakeEvt[ci] |
                        (handshakeFlag[ci] & ~modemStatusRd[ci]);
                    specialFlag[ci] <= specialCharEvt[ci] |
                        (specialFlag[ci] & ~intStatusRd[ci] & ~charRxEvt[ci]);
                end
            end
        end
    endgenerate

    // Device-wide flags; timer and pin live in channel 0 only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timerFlag <= 1'b0;
            pinFlag <= 1'b0;
            wakeFlag <= 1'b0;
        end else if (clkEn) begin
            timerFlag <= timerEvt | (timerFlag & ~timerCmdRead);
            pinFlag <= pinEvt | (pinFlag & ~pinLvlRead);
            wakeFlag <= wakeEvt | (wakeFlag & ~reqRead);
        end
    end

    // ==========================================================
    // Priority encode, registered so request and code move together
    // ==========================================================
    logic [2:0] chanCode [NCH];
    logic [NCH-1:0] next_request;
    logic [2:0] next_code [NCH];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            next_code[c] = gic_pkg::GIC_SRC_NONE;
            if (lineErrFlag[c] | rxReadyLvl[c]) begin
                next_code[c] = gic_pkg::GIC_SRC_RX;
            end else if (rxTimeoutLvl[c]) begin
                next_code[c] = gic_pkg::GIC_SRC_RXTO;
            end else if (txReadyFlag[c]) begin
                next_code[c] = gic_pkg::GIC_SRC_TX;
            end else if (modemFlag[c] | handshakeFlag[c] | flowCharFlag[c] |
                         specialFlag[c]) begin
                next_code[c] = gic_pkg::GIC_SRC_MODEM;
            end else if (c == 0 && pinFlag) begin
                next_code[c] = gic_pkg::GIC_SRC_PIN;
            end else if (c == 0 && timerFlag) begin
                next_code[c] = gic_pkg::GIC_SRC_TIMER;
            end
            next_request[c] = (next_code[c] != gic_pkg::GIC_SRC_NONE);
        end
        // Wake-up raises channel 0 request with code none
        next_request[0] = next_request[0] | (wakeFlag & ~reqRead);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chanRequest <= '0;
            for (int c = 0; c < NCH; c++) begin
                chanCode[c] <= gic_pkg::GIC_SRC_NONE;
            end
        end else if (clkEn) begin
            chanRequest <= next_request;
            for (int c = 0; c < NCH; c++) begin
                chanCode[c] <= next_code[c];
            end
        end
    end

    // ==========================================================
    // Writable configuration
    // ==========================================================
    // Timer period writes land only; the timer block guards them
    // against changes while it runs, so no running state is kept here
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timerPeriod <= {`GIC_RST_BYTE, `GIC_RST_BYTE};
            samplingRate <= `GIC_RST_BYTE;
            sleepCtrl <= `GIC_RST_BYTE;
            pinMask <= `GIC_RST_BYTE;
            pinLevel <= `GIC_RST_BYTE;
            pinTristate <= `GIC_RST_BYTE;
            pinPolarity <= `GIC_RST_BYTE;
            pinSelect <= `GIC_RST_PIN_SEL;
        end else if (clkEn) begin
            if (hit(laneWr, `GIC_OFF_TMR_LO)) begin
                timerPeriod[7:0] <= wbyte(`GIC_OFF_TMR_LO);
            end
            if (hit(laneWr, `GIC_OFF_TMR_HI)) begin
                timerPeriod[15:8] <= wbyte(`GIC_OFF_TMR_HI);
            end
            if (hit(laneWr, `GIC_OFF_SAMPLE)) begin
                samplingRate <= wbyte(`GIC_OFF_SAMPLE);
            end
            if (hit(laneWr, `GIC_OFF_SLEEP)) begin
                sleepCtrl <= wbyte(`GIC_OFF_SLEEP);
            end
            if (hit(laneWr, `GIC_OFF_PIN_MASK)) begin
                pinMask <= wbyte(`GIC_OFF_PIN_MASK);
            end
            if (hit(laneWr, `GIC_OFF_PIN_LVL)) begin
                pinLevel <= wbyte(`GIC_OFF_PIN_LVL);
            end
            if (hit(laneWr, `GIC_OFF_PIN_TRI)) begin
                pinTristate <= wbyte(`GIC_OFF_PIN_TRI);
            end
            if (hit(laneWr, `GIC_OFF_PIN_INV)) begin
                pinPolarity <= wbyte(`GIC_OFF_PIN_INV);
            end
            if (hit(laneWr, `GIC_OFF_PIN_SEL)) begin
                pinSelect <= wbyte(`GIC_OFF_PIN_SEL);
            end
        end
    end
    // Timer command is a one-cycle strobe; never reads back
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            timerCmd <= `GIC_RST_BYTE;
            timerCmdStb <= 1'b0;
        end else if (clkEn) begin
            timerCmdStb <= hit(laneWr, `GIC_OFF_TMR_CMD);
            if (hit(laneWr, `GIC_OFF_TMR_CMD)) begin
                timerCmd <= wbyte(`GIC_OFF_TMR_CMD);
            end
        end
    end

    // Soft reset bits hold until the reset logic reports completion
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            softReset <= `GIC_RST_BYTE;
        end else if (clkEn) begin
            if (hit(laneWr, `GIC_OFF_SOFT_RST)) begin
                softReset <= wbyte(`GIC_OFF_SOFT_RST);
            end else if (softResetDone) begin
                softReset <= `GIC_RST_BYTE;
            end
        end
    end

    // ==========================================================
    // Read data, registered one cycle after the read strobe
    // ==========================================================
    function automatic logic [7:0] rbyte(input logic [7:0] a);
        logic [7:0] v;
        logic [31:0] word;
        v = 8'h00;
        word = '0;
        // Request byte follows the codes, so a wake-up on its own reads as zero;
        // chanRequest still carries the wake-up to the host
        for (int c = 0; c < NCH; c++) begin
            word[c] = (chanCode[c] != gic_pkg::GIC_SRC_NONE);
        end
        word[`GIC_CODE0_LSB +: `GIC_CODE_W] = chanCode[0];
        word[`GIC_CODE1_LSB +: `GIC_CODE_W] = chanCode[1];
        case (a)
            `GIC_OFF_REQ: v = word[7:0];
            `GIC_OFF_CODE_LO: v = word[15:8];
            `GIC_OFF_CODE_MID: v = word[23:16];
            `GIC_OFF_CODE_HI: v = word[31:24];
            `GIC_OFF_TMR_CMD: v = (timerFlag & timerIntEn) ? `GIC_TMR_PEND_RD : 8'h00;
            `GIC_OFF_TMR_LO: v = timerPeriod[7:0];
            `GIC_OFF_TMR_HI: v = timerPeriod[15:8];
            `GIC_OFF_SAMPLE: v = samplingRate;
            `GIC_OFF_SLEEP: v = sleepCtrl;
            `GIC_OFF_REV: v = REV_CODE;
            `GIC_OFF_IDENT: v = IDENT_CODE;
            `GIC_OFF_PIN_MASK: v = pinMask;
            `GIC_OFF_PIN_LVL: v = pinLevel;
            `GIC_OFF_PIN_TRI: v = pinTristate;
            `GIC_OFF_PIN_INV: v = pinPolarity;
            `GIC_OFF_PIN_SEL: v = pinSelect;
            default: v = 8'h00; // Write-only, reserved, unmapped
        endcase
        return v;
    endfunction

    // All lanes sample one snapshot so a dword read is coherent
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= '0;
        end else if (clkEn) begin
            for (int k = 0; k < 4; k++) begin
                regRdData[8*k +: 8] <= laneRd[k] ? rbyte(laneAddr[k]) : 8'h00;
            end
        end
    end

endmodule // gic_global_int

// >>> testbench/gic_global_int_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the global interrupt word and config bank
module gic_global_int_monitor #(
    parameter int NCH = 2
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [3:0] byteEn,
    input wire logic [31:0] regRdData,
    input wire logic [NCH-1:0] rxReadyLvl,
    input wire logic [NCH-1:0] rxTimeoutLvl,
    input wire logic softResetDone,
    input wire logic [7:0] softReset,
    input wire logic timerCmdStb,
    input wire logic [7:0] pinSelect,
    input wire logic [NCH-1:0] chanRequest
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // Taken read of the interrupt word
    logic rdWord;
    assign rdWord = clkEn && regRd && regAddr == 8'h80;

    // ==========================================================
    // Assertions
    a_word_upper_zero: assert property (rdWord |=> regRdData[31:14] == 18'h0)
        else $error("interrupt word upper bits not zero");
    a_no_code_five: assert property (rdWord |=> regRdData[10:8] != 3'h5
        && regRdData[13:11] != 3'h5)
        else $error("reserved source code reported");
    a_ch1_no_device: assert property (rdWord |=> regRdData[13:11] < 3'h6)
        else $error("device source code seen in channel 1");
    a_req_upper_zero: assert property (rdWord |=> regRdData[7:2] == 6'h0)
        else $error("request byte upper bits not zero");
    a_ch1_code_agree: assert property (rdWord && byteEn[0] && byteEn[1] |=>
        regRdData[1] == (regRdData[13:11] != 3'h0))
        else $error("channel 1 request bit and code disagree");
    a_ch0_code_agree: assert property (rdWord && byteEn[0] && byteEn[1] |=>
        regRdData[0] == (regRdData[10:8] != 3'h0))
        else $error("channel 0 request bit and code disagree");
    a_rx_ready_req: assert property (clkEn && rxReadyLvl[0] |=> chanRequest[0])
        else $error("receive ready without channel 0 request");
    a_rx_timeout_req: assert property (clkEn && rxTimeoutLvl[1] |=> chanRequest[1])
        else $error("receive timeout without channel 1 request");
    a_soft_wo_zero: assert property (clkEn && regRd && regAddr == 8'h8a && byteEn == 4'h1
        |=> regRdData == 32'h0)
        else $error("write-only register read back nonzero");
    a_soft_self_clear: assert property (clkEn && softResetDone && !regWr
        |-> ##[1:2] softReset == 8'h00)
        else $error("soft reset bits did not clear");
    a_cmd_strobe: assert property (clkEn && regWr && byteEn[0] && regAddr == 8'h84 |=>
        timerCmdStb)
        else $error("timer command strobe missing after write");
    a_sel_reset_ff: assert property ($rose(arst_n) |-> pinSelect == 8'hff)
        else $error("pin select not ff after reset");
    a_lane_zero: assert property (clkEn && regRd && byteEn == 4'h1
        |=> regRdData[31:8] == 24'h0)
        else $error("disabled lanes not zero");

    // Main scenarios seen
    c_timer_code: cover property (rdWord ##1 regRdData[10:8] == 3'h7);
    c_ch1_modem: cover property (rdWord ##1 regRdData[13:11] == 3'h4);
    c_soft_reset: cover property (softReset != 8'h00);
endmodule // gic_global_int_monitor

bind gic_global_int gic_global_int_monitor #(.NCH(NCH)) u_gic_global_int_monitor (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .byteEn(byteEn), .regRdData(regRdData),
    .rxReadyLvl(rxReadyLvl), .rxTimeoutLvl(rxTimeoutLvl),
    .softResetDone(softResetDone), .softReset(softReset), .timerCmdStb(timerCmdStb),
    .pinSelect(pinSelect), .chanRequest(chanRequest));

// >>> testbench/test_global_interrupt_and_device_config.sv
`timescale 1ns/10ps
// ==========================================================
// Register-level bench for the global interrupt and config bank
module test_global_interrupt_and_device_config;
    localparam int NCH = 2;
    localparam logic [7:0] REV = 8'ha7; // Arbitrary value
    localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value
    localparam int NT = 11;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic regRd = 1'b0;
    logic regWr = 1'b0;
    logic [3:0] byteEn = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic [NCH-1:0] rxReadyLvl = '0;
    logic [NCH-1:0] rxTimeoutLvl = '0;
    logic timerIntEn = 1'b0;
    logic [23:0] ev = 24'h0; // All event and clear pulses, two bits per channel kind, one per device-wide kind
    logic [31:0] regRdData;
    logic [15:0] timerPeriod;
    logic [7:0] softReset;
    logic [7:0] timerCmd;
    logic [7:0] samplingRate;
    logic [7:0] sleepCtrl;
    logic [7:0] pinMask;
    logic [7:0] pinLevel;
    logic [7:0] pinTristate;
    logic [7:0] pinPolarity;
    logic [7:0] pinSelect;
    logic [NCH-1:0] chanRequest;
    logic [31:0] rd;
    logic [23:0] s;
    logic [23:0] c;
    logic [31:0] e;
    logic [31:0] f;
    int miscompares = 0;
    int checked = 0;
    // Source pulse, expected word, clearing pulse, word after clearing
    logic [111:0] tbl [NT] = '{
        {24'h000005, 32'h101, 24'h004000, 32'h301}, {24'h0, 32'h301, 24'h010000, 32'h0},
        {24'h000020, 32'h2002, 24'h020000, 32'h0}, {24'h000080, 32'h2002, 24'h080000, 32'h0},
        {24'h000100, 32'h401, 24'h040000, 32'h0}, {24'h000400, 32'h401, 24'h001000, 32'h0},
        {24'h000800, 32'h2002, 24'h020000, 32'h0}, {24'h000002, 32'h802, 24'h004000, 32'h802},
        {24'h0, 32'h802, 24'h008000, 32'h0}, {24'h000049, 32'h1903, 24'h004000, 32'h1c03},
        {24'h0, 32'h1c03, 24'h060000, 32'h0}};

    always #20 sys_clk = ~sys_clk;

    gic_global_int #(.NCH(NCH), .REV_CODE(REV), .IDENT_CODE(IDENT)) u_gic_global_int (
        .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regRd(regRd), .regWr(regWr), .byteEn(byteEn), .regWrData(regWrData),
        .regRdData(regRdData), .rxReadyLvl(rxReadyLvl), .rxTimeoutLvl(rxTimeoutLvl),
        .lineErrEvt(ev[1:0]), .txReadyEvt(ev[3:2]), .flowCharEvt(ev[5:4]),
        .modemEvt(ev[7:6]), .handshakeEvt(ev[9:8]), .specialCharEvt(ev[11:10]),
        .charRxEvt(ev[13:12]), .lineStatusRd(ev[15:14]), .intStatusRd(ev[17:16]),
        .modemStatusRd(ev[19:18]), .timerEvt(ev[20]), .timerIntEn(timerIntEn),
        .pinEvt(ev[21]), .wakeEvt(ev[22]), .softResetDone(ev[23]),
        .timerCmd(timerCmd), .timerCmdStb(), .timerPeriod(timerPeriod),
        .samplingRate(samplingRate), .softReset(softReset), .sleepCtrl(sleepCtrl),
        .pinMask(pinMask), .pinLevel(pinLevel), .pinTristate(pinTristate),
        .pinPolarity(pinPolarity), .pinSelect(pinSelect), .chanRequest(chanRequest));

    // ==========================================================
    // Access tasks: inputs move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Request held for the taking edge; read data stands one cycle only, take it then
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
        regAddr = a;
        byteEn = be;
        regWrData = d;
        regWr = wr;
        regRd = !wr;
        tick(1);
        rd = regRdData;
        regRd = 1'b0;
        regWr = 1'b0;
        tick(1);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
        access(1'b0, a, be, 32'h0);
        chk(rd, exp);
    endtask

    // Two extra cycles let the flag reach the request outputs
    task automatic pulse(input logic [23:0] m);
        ev = m;
        tick(1);
        ev = 24'h0;
        tick(2);
    endtask

    task automatic done(input string name);
        $display("%s finished", name);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the sequence needs about 200 cycles, allow far more
    initial begin
        #(40 * 5000);
        miscompares++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        tick(6);
        arst_n = 1'b1;
        rdchk(8'h80, 4'hf, 32'h0);
        rdchk(8'h84, 4'hf, 32'h0);
        rdchk(8'h88, 4'hf, 32'h0);
        rdchk(8'h8c, 4'hf, {16'h0, IDENT, REV});
        rdchk(8'h90, 4'hf, 32'hff000000);
        rdchk(8'h91, 4'h7, 32'h00ff0000);
        rdchk(8'h94, 4'h1, 32'h0);
        done("reset values");
        // Levels from the receive side on both channels
        rxReadyLvl = 2'b01;
        rxTimeoutLvl = 2'b11;
        tick(3);
        rdchk(8'h80, 4'hf, 32'h00001103);
        rxReadyLvl = 2'b00;
        rxTimeoutLvl = 2'b01;
        tick(3);
        rdchk(8'h80, 4'hf, 32'h00000201);
        rxTimeoutLvl = 2'b00;
        tick(3);
        rdchk(8'h80, 4'hf, 32'h0);
        done("receive levels");
        // Each source, priority pairs and wrong-channel clears
        for (int i = 0; i < NT; i++) begin
            {s, e, c, f} = tbl[i];
            pulse(s);
            rdchk(8'h80, 4'hf, e);
            pulse(c);
            rdchk(8'h80, 4'hf, f);
        end
        done("channel sources");
        // Device-wide sources appear in channel 0 only
        timerIntEn = 1'b1;
        pulse(24'h300000);
        rdchk(8'h80, 4'h3, 32'h00000601);
        rdchk(8'h90, 4'h1, 32'h0);
        tick(1);
        rdchk(8'h80, 4'h3, 32'h00000701);
        rdchk(8'h84, 4'h1, 32'h00000001);
        tick(1);
        rdchk(8'h84, 4'h1, 32'h0);
        rdchk(8'h80, 4'h3, 32'h0);
        done("timer and pins");
        // Wake-up request cleared by a request byte read
        pulse(24'h400000);
        chk({30'h0, chanRequest}, 32'h1);
        access(1'b0, 8'h80, 4'h1, 32'h0);
        chk(rd, 32'h0);
        tick(1);
        rdchk(8'h80, 4'h1, 32'h0);
        done("wake-up");
        // Write-only soft reset, byte lanes, read-only places
        access(1'b1, 8'h8a, 4'h1, 32'h3);
        chk({24'h0, softReset}, 32'h3);
        rdchk(8'h8a, 4'h1, 32'h0);
        pulse(24'h800000);
        chk({24'h0, softReset}, 32'h0);
        access(1'b1, 8'h86, 4'h3, 32'h00003412);
        chk({16'h0, timerPeriod}, 32'h3412);
        rdchk(8'h86, 4'h3, 32'h3412);
        access(1'b1, 8'h80, 4'hf, 32'hffffffff);
        access(1'b1, 8'h8c, 4'h3, 32'h0000ffff);
        rdchk(8'h8c, 4'hf, {16'h0, IDENT, REV});
        rdchk(8'h80, 4'hf, 32'h0);
        access(1'b1, 8'h88, 4'hf, 32'h66000005);
        chk({sleepCtrl, softReset, 8'h0, samplingRate}, 32'h66000005);
        access(1'b1, 8'h8f, 4'h1, 32'h000000c3);
        chk({24'h0, pinMask}, 32'hc3);
        access(1'b1, 8'h90, 4'hf, 32'h11223344);
        chk({pinSelect, pinPolarity, pinTristate, pinLevel}, 32'h11223344);
        access(1'b1, 8'h84, 4'h1, 32'h00000009);
        chk({24'h0, timerCmd}, 32'h9);
        rdchk(8'h84, 4'h1, 32'h0);
        done("config access");
        // Clock enable low freezes flags and ignores register writes
        clkEn = 1'b0;
        pulse(24'h000001);
        access(1'b1, 8'h88, 4'h1, 32'h0);
        clkEn = 1'b1;
        chk({24'h0, samplingRate}, 32'h5);
        rdchk(8'h80, 4'hf, 32'h0);
        done("clock enable");
        end_of_test();
    end
endmodule // test_global_interrupt_and_device_config
